// *** rtl/flash_ctrl_pkg.sv ***
package flash_ctrl_pkg;

   // ---------------------------------------------------------------
   // array geometry
   // ---------------------------------------------------------------
   localparam int unsigned FLASH_KB    = 16;
   localparam int unsigned FLASH_BYTES = FLASH_KB * 1024;
   localparam logic [15:0] FLASH_BASE  = 16'(32'h10000 - FLASH_BYTES);
   localparam logic [15:0] SECT0_LO    = 16'hf000;
   localparam logic [15:0] SECT1_LO    = 16'he000;
   localparam logic [15:0] SECT_TOP    = 16'hffff;
   localparam logic [15:0] SECT_SIZE   = 16'h1000;
   localparam logic [1:0]  SECT_NONE   = 2'h3;
   localparam logic [7:0]  ERASED_BYTE = 8'hff;

   // ---------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_CTRL   = 8'h29;
   localparam logic [7:0] IDX_OPTION = 8'h2c;
   localparam logic [7:0] IDX_ADDR   = 8'h2d;
   localparam logic [7:0] IDX_DATA   = 8'h2e;
   localparam logic [7:0] IDX_PINS   = 8'h2f;

   // control/status fields
   localparam int unsigned CS_PROG    = 0;
   localparam int unsigned CS_SERASE  = 1;
   localparam int unsigned CS_MERASE  = 2;
   localparam int unsigned CS_DONE    = 5;
   localparam int unsigned CS_REFUSED = 6;
   localparam int unsigned CS_BUSY    = 7;
   localparam logic [7:0]  CS_RESET   = 8'h00;

   // pin register fields
   localparam int unsigned PIN_APP_OUT = 0;
   localparam int unsigned PIN_APP_OE  = 1;
   localparam int unsigned PIN_TOOL    = 4;
   localparam int unsigned PIN_SCLK    = 5;
   localparam int unsigned PIN_SDATA   = 6;
   localparam int unsigned PIN_VPP     = 7;

   typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_ERASE} seq_state_t;

   // ---------------------------------------------------------------
   // sector decode
   // ---------------------------------------------------------------
   // sectors 0 and 1 are 4K each at the top; sector 0 holds vectors
   function automatic logic [1:0] sector_of(input logic [15:0] a);
      if (a < FLASH_BASE)
         return SECT_NONE;
      else if (a >= SECT0_LO)
         return 2'h0;
      else if (a >= SECT1_LO)
         return 2'h1;
      else
         return 2'h2;
   endfunction

   function automatic logic [15:0] sector_lo(input logic [1:0] s);
      case (s)
         2'h0:    return SECT0_LO;
         2'h1:    return SECT1_LO;
         default: return FLASH_BASE;
      endcase
   endfunction

   function automatic logic [15:0] sector_hi(input logic [1:0] s);
      return (s == 2'h2) ? 16'(SECT1_LO - 16'h1)
                         : 16'(sector_lo(s) + SECT_SIZE - 16'h1);
   endfunction

endpackage

// *** rtl/flash_mem_if.sv ***
`timescale 1ns/10ps
`default_nettype none

interface flash_mem_if;
   logic        we;
   logic [15:0] waddr;
   logic [7:0]  wdata;
   logic [15:0] raddr;
   logic [7:0]  rdata;

   modport ctrl (output we, waddr, wdata, raddr, input rdata);
   modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface

`default_nettype wire

// *** rtl/pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
   parameter int unsigned W = 4
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   // pins in, synchronised levels out
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;

   sync_t q;
   sync_t d;

   // first stage feeds only the second stage
   always_comb begin
      d    = q;
      d.s1 = pin_in;
      d.s2 = q.s1;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         q <= '0;
      else
         q <= d;
   end

   assign pin_out = q.s2;

endmodule

`default_nettype wire

// *** rtl/flash_array.sv ***
`timescale 1ns/10ps
`default_nettype none

module flash_array (
   // clock
   input  wire logic ref_clk,
   // access port
   flash_mem_if.mem  port
);

   localparam int unsigned AW = $clog2(flash_ctrl_pkg::FLASH_BYTES);

   typedef struct packed {
      logic [7:0] rdata;
   } arr_t;

   arr_t q;
   arr_t d;

   logic [7:0]  mem [flash_ctrl_pkg::FLASH_BYTES];
   logic [15:0] woff;
   logic [15:0] roff;

   // offsets into the array; only the addressed byte is touched
   always_comb begin
      woff    = 16'(port.waddr - flash_ctrl_pkg::FLASH_BASE);
      roff    = 16'(port.raddr - flash_ctrl_pkg::FLASH_BASE);
      d       = q;
      d.rdata = mem[roff[AW-1:0]];
   end

   // one byte per write, every other cell keeps its contents
   always_ff @(posedge ref_clk) begin
      q <= d;
      if (port.we) begin
         mem[woff[AW-1:0]] <= port.wdata;
      end
   end

   assign port.rdata = q.rdata;

endmodule

`default_nettype wire

// *** rtl/flash_program_ctrl.sv ***
// Contract
// - erase the array as one whole block or one sector at a time.
// - program one byte per operation, only with programming voltage present.
// - erasing or programming one sector leaves all other sectors intact.
// - sectors 0 and 1 are fixed 4K blocks at the top of space.
// - sector 0 spans f000h to ffffh and holds the vectors.
// - sector count follows array size: 4K one, 8K two, above three.
// - read-out protection blocks external read-out and flash writes.
// - removing read-out protection first erases the whole program memory.
// - a protection bit in the option byte turns protection on and off.
// - tool and in-circuit modes may program and erase every sector.
// - in-application mode may not program or erase sector 0.
// - with the tool attached, serial pins are unavailable to the application.
// - serial data is bidirectional; serial clock clocks the link (here the clock is only synchronised and read back in the pin register).
// - control/status register resets to zero and steers program/erase.
// - read-only-memory parts fix protection by mask, not by bit.
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module flash_program_ctrl #(
   parameter bit ROM_PART     = 1'b0,
   parameter bit MASK_PROTECT = 1'b0,
   parameter bit OPTION_INIT  = 1'b0
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // programming pins
   input  wire logic        tool_attached,
   input  wire logic        prog_voltage_select,
   input  wire logic        incircuit_serial_clock,
   input  wire logic        incircuit_serial_data_in,
   output logic             incircuit_serial_data_out,
   output logic             incircuit_serial_data_oe
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic                       rd_pend;
      logic                       wr_pend;
      logic [7:0]                 idx;
      logic                       ready;
      logic [31:0]                rdata;
      logic                       done;
      logic                       refused;
      logic                       protect;
      logic                       unprot_pend;
      logic [15:0]                addr;
      logic [7:0]                 wdata;
      logic                       app_out;
      logic                       app_oe;
      flash_ctrl_pkg::seq_state_t st;
      logic [15:0]                ptr;
      logic [15:0]                last;
      logic                       we;
      logic [15:0]                waddr;
      logic [7:0]                 wbyte;
      logic                       sd_out;
      logic                       sd_oe;
   } ctl_t;

   ctl_t        q;
   ctl_t        d;
   logic [3:0]  pins_s;
   logic        tool_s;
   logic        vpp_s;
   logic        acc;
   logic        busy;
   logic        refuse;
   logic [7:0]  cs_rd;
   logic [31:0] rd_word;
   logic [1:0]  sect;
   logic        cs_prog_req;

   flash_mem_if mem_if ();

   // ---------------------------------------------------------------
   // pin synchronisers and flash array
   // ---------------------------------------------------------------
   pin_sync #(.W(4)) u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin_in  ({incircuit_serial_data_in, incircuit_serial_clock,
                 prog_voltage_select, tool_attached}),
      .pin_out (pins_s)
   );

   flash_array u_array (
      .ref_clk (ref_clk),
      .port    (mem_if.mem)
   );

   assign tool_s = pins_s[0];
   assign vpp_s  = pins_s[1];

   // write port from registers, read port follows the address register
   assign mem_if.we    = q.we;
   assign mem_if.waddr = q.waddr;
   assign mem_if.wdata = q.wbyte;
   assign mem_if.raddr = q.addr;

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always_comb begin
      busy    = (q.st != flash_ctrl_pkg::ST_IDLE);
      cs_rd = flash_ctrl_pkg::CS_RESET;
      cs_rd[flash_ctrl_pkg::CS_BUSY]    = busy;
      cs_rd[flash_ctrl_pkg::CS_REFUSED] = q.refused;
      cs_rd[flash_ctrl_pkg::CS_DONE]    = q.done;
      rd_word = 32'h0;
      case (q.idx)
         flash_ctrl_pkg::IDX_CTRL: begin
            rd_word[7:0] = cs_rd;
         end
         flash_ctrl_pkg::IDX_OPTION: begin
            rd_word[0] = q.protect;
         end
         flash_ctrl_pkg::IDX_ADDR: begin
            rd_word[15:0] = q.addr;
         end
         flash_ctrl_pkg::IDX_DATA: begin
            // no content leaves through the tool while protected
            if (!(q.protect && tool_s))
               rd_word[7:0] = mem_if.rdata;
         end
         flash_ctrl_pkg::IDX_PINS: begin
            rd_word[flash_ctrl_pkg::PIN_APP_OUT] = q.app_out;
            rd_word[flash_ctrl_pkg::PIN_APP_OE]  = q.app_oe;
            rd_word[flash_ctrl_pkg::PIN_TOOL]    = tool_s;
            rd_word[flash_ctrl_pkg::PIN_SCLK]    = pins_s[2];
            rd_word[flash_ctrl_pkg::PIN_SDATA]   = pins_s[3];
            rd_word[flash_ctrl_pkg::PIN_VPP]     = vpp_s;
         end
         default: begin
            rd_word = 32'h0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // bus, request check and sequencer
   // ---------------------------------------------------------------
   always_comb begin
      d             = q;
      d.we          = 1'b0;
      refuse        = 1'b0;
      cs_prog_req   = 1'b0;
      sect          = flash_ctrl_pkg::sector_of(q.addr);
      acc           = hsel && hready && htrans[1];

      // reads hold hreadyout low one cycle so data is a flop
      if (q.rd_pend) begin
         d.rd_pend = 1'b0;
         d.ready   = 1'b1;
         d.rdata   = rd_word;
      end

      if (q.wr_pend) begin
         d.wr_pend = 1'b0;
         case (q.idx)
            flash_ctrl_pkg::IDX_CTRL: begin
               // flags clear by writing one; a new event below wins
               if (hwdata[flash_ctrl_pkg::CS_DONE])
                  d.done = 1'b0;
               if (hwdata[flash_ctrl_pkg::CS_REFUSED])
                  d.refused = 1'b0;
               cs_prog_req = hwdata[flash_ctrl_pkg::CS_PROG];
               if (|hwdata[2:0]) begin
                  if (busy || q.protect || !vpp_s)
                     refuse = 1'b1;
                  else if (hwdata[flash_ctrl_pkg::CS_MERASE]) begin
                     if (!tool_s)
                        refuse = 1'b1;
                     else begin
                        d.ptr  = flash_ctrl_pkg::FLASH_BASE;
                        d.last = flash_ctrl_pkg::SECT_TOP;
                        d.st   = flash_ctrl_pkg::ST_ERASE;
                     end
                  end
                  else if (sect == flash_ctrl_pkg::SECT_NONE)
                     refuse = 1'b1;
                  else if (!tool_s && sect == 2'h0)
                     refuse = 1'b1;
                  else if (hwdata[flash_ctrl_pkg::CS_SERASE]) begin
                     d.ptr  = flash_ctrl_pkg::sector_lo(sect);
                     d.last = flash_ctrl_pkg::sector_hi(sect);
                     d.st   = flash_ctrl_pkg::ST_ERASE;
                  end
                  else
                     d.st = flash_ctrl_pkg::ST_PROG;
               end
            end
            flash_ctrl_pkg::IDX_OPTION: begin
               // mask parts keep their protection whatever is written
               if (ROM_PART || hwdata[0] == q.protect)
                  d.protect = q.protect;
               else if (busy || !tool_s || !vpp_s)
                  refuse = 1'b1;
               else if (hwdata[0])
                  d.protect = 1'b1;
               else begin
                  // wipe everything before protection may drop
                  d.unprot_pend = 1'b1;
                  d.ptr         = flash_ctrl_pkg::FLASH_BASE;
                  d.last        = flash_ctrl_pkg::SECT_TOP;
                  d.st          = flash_ctrl_pkg::ST_ERASE;
               end
            end
            flash_ctrl_pkg::IDX_ADDR: begin
               if (!busy)
                  d.addr = hwdata[15:0];
            end
            flash_ctrl_pkg::IDX_DATA: begin
               if (!busy)
                  d.wdata = hwdata[7:0];
            end
            flash_ctrl_pkg::IDX_PINS: begin
               d.app_out = hwdata[flash_ctrl_pkg::PIN_APP_OUT];
               d.app_oe  = hwdata[flash_ctrl_pkg::PIN_APP_OE];
            end
            default: begin
               d.wr_pend = 1'b0;
            end
         endcase
      end

      // address phase; anything outside the small window maps to 0
      if (acc) begin
         d.idx = (haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0)
                 ? haddr[9:2] : 8'h00;
         if (hwrite)
            d.wr_pend = 1'b1;
         else begin
            d.rd_pend = 1'b1;
            d.ready   = 1'b0;
         end
      end

      // one array write per cycle; erase walks the range byte by byte
      case (q.st)
         flash_ctrl_pkg::ST_IDLE: begin
            d.we = 1'b0;
         end
         flash_ctrl_pkg::ST_PROG: begin
            d.we    = 1'b1;
            d.waddr = q.addr;
            d.wbyte = q.wdata;
            d.st    = flash_ctrl_pkg::ST_IDLE;
            d.done  = 1'b1;
         end
         flash_ctrl_pkg::ST_ERASE: begin
            d.we    = 1'b1;
            d.waddr = q.ptr;
            d.wbyte = flash_ctrl_pkg::ERASED_BYTE;
            d.ptr   = 16'(q.ptr + 16'h1);
            if (q.ptr == q.last) begin
               d.st   = flash_ctrl_pkg::ST_IDLE;
               d.done = 1'b1;
               if (q.unprot_pend) begin
                  d.protect     = 1'b0;
                  d.unprot_pend = 1'b0;
               end
            end
         end
         default: begin
            d.st = flash_ctrl_pkg::ST_IDLE;
         end
      endcase

      if (refuse)
         d.refused = 1'b1;

      // attached tool owns the serial pins; application drive is cut
      d.sd_oe  = q.app_oe && !tool_s;
      d.sd_out = q.app_out && !tool_s;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         q         <= '0;
         q.ready   <= 1'b1;
         q.protect <= ROM_PART ? MASK_PROTECT : OPTION_INIT;
      end
      else begin
         q <= d;
      end
   end

   assign hreadyout                 = q.ready;
   assign hrdata                    = q.rdata;
   assign hresp                     = 1'b0;
   assign incircuit_serial_data_out = q.sd_out;
   assign incircuit_serial_data_oe  = q.sd_oe;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_PROG_ONE_BYTE: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (q.st == flash_ctrl_pkg::ST_PROG) |=>
         (q.we && q.waddr == $past(q.addr) && q.wbyte == $past(q.wdata)
          && q.st == flash_ctrl_pkg::ST_IDLE))
      else $error("program did not write exactly one byte");

   AST_ERASE_END: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (q.st == flash_ctrl_pkg::ST_ERASE && q.ptr == q.last) |=>
         (q.we && q.wbyte == 8'hff && q.done
          && q.st == flash_ctrl_pkg::ST_IDLE))
      else $error("erase did not finish on its last byte");

   AST_SECTOR_ERASE_RANGE: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (q.st == flash_ctrl_pkg::ST_ERASE && !q.unprot_pend
       && q.last != 16'hffff) |->
         (flash_ctrl_pkg::sector_of(q.ptr) ==
          flash_ctrl_pkg::sector_of(q.last)))
      else $error("sector erase strayed outside its sector");

   AST_NO_WRITE_OUTSIDE: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      q.we |-> (flash_ctrl_pkg::sector_of(q.waddr) != 2'h3))
      else $error("write below the available sectors");

   AST_PROTECT_BLOCKS: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (q.protect && !q.unprot_pend) |=>
         !(q.we && q.wbyte != 8'hff))
      else $error("byte programmed while protected");

   AST_UNPROTECT_ERASES: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      $fell(q.protect) |->
         ($past(q.unprot_pend) && q.done && $past(q.ptr) == 16'hffff))
      else $error("protection dropped without full erase");

   AST_INAPP_SECTOR0: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (q.wr_pend && cs_prog_req && !busy && !q.protect && vpp_s
       && !tool_s && sect == 2'h0) |=>
         (q.refused && q.st == flash_ctrl_pkg::ST_IDLE)
         ##1 !(q.we && flash_ctrl_pkg::sector_of(q.waddr) == 2'h0))
      else $error("sector 0 request accepted in application mode");

   AST_RESET_CLEAN: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      !$past(rst_n) |->
         (!q.done && !q.refused && q.st == flash_ctrl_pkg::ST_IDLE
          && q.ready && !q.sd_oe))
      else $error("control state not clear after reset");

   AST_TOOL_OWNS_PINS: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      tool_s [*2] |-> !incircuit_serial_data_oe)
      else $error("application drives serial data with tool attached");

endmodule

`default_nettype wire

// *** verification/tool_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module tool_model (
   // clock
   input  wire logic ref_clk,
   // bench requests
   input  wire logic attach_req,
   input  wire logic vpp_req,
   // device side of serial data
   input  wire logic data_oe,
   input  wire logic data_out,
   // pins toward the device
   output logic      tool_attached,
   output logic      prog_voltage_select,
   output logic      serial_clock,
   output logic      serial_data
);
   logic       toggle_ff = 1'b0;
   logic [6:0] pulse_ff  = 7'h00;

   // released line flips each cycle so a stale level hides nothing
   always_ff @(posedge ref_clk) toggle_ff <= ~toggle_ff;

   // entry train of 36 link clock pulses, then the clock stands still
   always_ff @(posedge ref_clk) begin
      if (!attach_req)
         pulse_ff <= 7'h00;
      else if (pulse_ff != 7'h48)
         pulse_ff <= pulse_ff + 7'h01;
   end

   assign serial_clock = pulse_ff[0];
   assign serial_data = data_oe ? data_out : toggle_ff;
   // tool reports attach once entry is done; it drives no reset
   assign tool_attached = (pulse_ff == 7'h48);
   assign prog_voltage_select = vpp_req;
endmodule

`default_nettype wire

// *** verification/sector_flash_program_control_bench.sv ***
`timescale 1ns/10ps
`default_nettype none

module sector_flash_program_control_bench;
   localparam logic [31:0] A_CTRL = {22'h0, flash_ctrl_pkg::IDX_CTRL, 2'h0};
   localparam logic [31:0] A_OPT  = {22'h0, flash_ctrl_pkg::IDX_OPTION, 2'h0};
   localparam logic [31:0] A_ADDR = {22'h0, flash_ctrl_pkg::IDX_ADDR, 2'h0};
   localparam logic [31:0] A_DATA = {22'h0, flash_ctrl_pkg::IDX_DATA, 2'h0};
   localparam logic [31:0] A_PINS = {22'h0, flash_ctrl_pkg::IDX_PINS, 2'h0};
   logic        ref_clk = 1'b0;
   logic        rst_n   = 1'b0;
   logic        hsel    = 1'b0;
   logic [31:0] haddr   = 32'h0;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'b0;
   logic [31:0] hwdata  = 32'h0;
   logic        attach  = 1'b1;
   logic        vpp     = 1'b1;
   wire  logic  hreadyout, hresp, sd_out, sd_oe, tool_at, vpp_pin, sclk, sdat;
   wire  logic [31:0] hrdata;
   logic [31:0] r;
   int          n_mismatch = 0;
   int          checks = 0;

   // bench supplies the main clock to device and tool
   always #20 ref_clk = ~ref_clk;

   flash_program_ctrl u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .tool_attached(tool_at),
      .prog_voltage_select(vpp_pin), .incircuit_serial_clock(sclk),
      .incircuit_serial_data_in(sdat), .incircuit_serial_data_out(sd_out),
      .incircuit_serial_data_oe(sd_oe));
   tool_model u_tool (.ref_clk(ref_clk), .attach_req(attach), .vpp_req(vpp),
      .data_oe(sd_oe), .data_out(sd_out), .tool_attached(tool_at),
      .prog_voltage_select(vpp_pin), .serial_clock(sclk), .serial_data(sdat));

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task complete_run;
      $display("mismatches %0d, comparisons %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task hang(input string m);
      n_mismatch++;
      $display("mismatch at %0t: timeout %s", $time, m);
      complete_run;
   endtask

   // bounded wait for hready sampled high at a rising edge
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) hang("bus");
   endtask

   task bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= a;
      wait_rdy;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy;
      rd = hrdata;
   endtask

   task wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   // poll until done or refused, then clear both flags
   task status(output logic [31:0] s);
      int n;
      n = 0;
      do begin
         bus(1'b0, A_CTRL, 32'h0, s);
         n++;
      end while (s[5] !== 1'b1 && s[6] !== 1'b1 && n < 10000);
      if (n >= 10000) hang("sequencer");
      wr(A_CTRL, 32'h60);
   endtask

   task op(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c,
           input logic [31:0] exp);
      logic [31:0] s;
      wr(A_ADDR, {16'h0, a});
      wr(A_DATA, {24'h0, d});
      wr(A_CTRL, {24'h0, c});
      status(s);
      chk(s & 32'h60, exp, "operation outcome");
   endtask

   // array read is registered, so leave two cycles after the address
   task peek(input logic [15:0] a, input logic [31:0] exp);
      logic [31:0] v;
      wr(A_ADDR, {16'h0, a});
      repeat (2) @(posedge ref_clk);
      bus(1'b0, A_DATA, 32'h0, v);
      chk(v, exp, "flash byte");
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task t_reset;
      bus(1'b0, A_CTRL, 32'h0, r);
      chk(r, 32'h0, "control reset value");
      bus(1'b0, 32'h400, 32'h0, r);
      chk(r, 32'h0, "unmapped read");
      chk({31'h0, hresp}, 32'h0, "response");
   endtask

   task t_program;
      op(16'hc010, 8'h5a, 8'h01, 32'h20);
      peek(16'hc010, 32'h5a);
      op(16'hf010, 8'ha5, 8'h01, 32'h20);
      op(16'h0100, 8'h11, 8'h01, 32'h40);
      vpp <= 1'b0;
      repeat (4) @(posedge ref_clk);
      op(16'hc011, 8'h22, 8'h01, 32'h40);
      vpp <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask

   task t_sector_erase;
      op(16'he123, 8'h00, 8'h02, 32'h20);
      peek(16'he000, 32'hff);
      peek(16'hefff, 32'hff);
      peek(16'hc010, 32'h5a);
      peek(16'hf010, 32'ha5);
   endtask

   task t_in_app;
      attach <= 1'b0;
      wr(A_PINS, 32'h3);
      repeat (4) @(posedge ref_clk);
      chk({30'h0, sd_oe, sd_out}, 32'h3, "app pins");
      op(16'hf010, 8'h00, 8'h01, 32'h40);
      op(16'hf010, 8'h00, 8'h04, 32'h40);
      peek(16'hf010, 32'ha5);
      op(16'he010, 8'h3c, 8'h01, 32'h20);
      peek(16'he010, 32'h3c);
      attach <= 1'b1;
      // tool counts as attached only after its entry pulse train
      repeat (80) @(posedge ref_clk);
      chk({31'h0, sd_oe}, 32'h0, "pin with tool");
      bus(1'b0, A_PINS, 32'h0, r);
      chk(r & 32'h33, 32'h13, "pin register");
   endtask

   task t_protect;
      op(16'hf020, 8'h00, 8'h04, 32'h20);
      peek(16'hc010, 32'hff);
      op(16'hf010, 8'ha5, 8'h01, 32'h20);
      wr(A_OPT, 32'h1);
      bus(1'b0, A_OPT, 32'h0, r);
      chk(r, 32'h1, "option set");
      peek(16'hc010, 32'h0);
      op(16'hc012, 8'h77, 8'h01, 32'h40);
      wr(A_OPT, 32'h0);
      status(r);
      chk(r & 32'h60, 32'h20, "unprotect erase");
      bus(1'b0, A_OPT, 32'h0, r);
      chk(r, 32'h0, "option cleared");
      peek(16'hc010, 32'hff);
      peek(16'hf010, 32'hff);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      // wait out the tool's entry train and the pin synchronisers
      repeat (80) @(posedge ref_clk);
      t_reset;
      t_program;
      t_sector_erase;
      t_in_app;
      t_protect;
      complete_run;
   end
endmodule

`default_nettype wire
